// >>> bench/rct_reset_cause_asserts.sv
// Port-level checks on the reset cause tracker
`timescale 1ns/1ns
`include "rct_map.vh"
module rct_reset_cause_asserts (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire [31:0] hrdata,
    input wire hresp,
    input wire wdt_timeout,
    input wire config_mismatch,
    input wire reset_instruction,
    input wire stack_full,
    input wire stack_underflow,
    input wire deep_sleep_reset,
    input wire deep_sleep_active,
    input wire regulator_enabled,
    input wire deep_sleep_supply_watch_enable,
    input wire device_reset,
    input wire interrupt_priority_enable,
    input wire core_monitor_active,
    input wire supply_monitor_active,
    input wire irq
);
    wire tk = hsel & htrans[1] & hready;
    wire ctl_a = haddr[11:0] == `RCT_CTRL_OFS;
    wire rq = wdt_timeout | config_mismatch | reset_instruction | stack_full | stack_underflow | deep_sleep_reset;
    reg up_q;
    // Keeps $past away from values sampled inside reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_unimpl_zero: assert property (tk && !hwrite && ctl_a |=> ##1 !hrdata[6] && hrdata[31:8] == 24'h000000)
        else $error("unused control bits not zero");
    a_brown_regoff: assert property (tk && !hwrite && ctl_a && !regulator_enabled |=> ##1 !hrdata[0])
        else $error("brown-out flag set with regulator off");
    a_prio_write: assert property (tk && hwrite && ctl_a ##1 !rq |=> interrupt_priority_enable == $past(hwdata[7]))
        else $error("priority enable not written");
    a_prio_only_write: assert property ($rose(interrupt_priority_enable) |-> $past(tk && hwrite && ctl_a, 2))
        else $error("priority enable rose without write");
    a_reset_follows: assert property (rq |=> device_reset && !interrupt_priority_enable)
        else $error("reset request not followed");
    a_core_monitor: assert property (up_q |-> core_monitor_active == ($past(regulator_enabled) && !$past(deep_sleep_active)))
        else $error("core monitor state wrong");
    a_supply_monitor: assert property (up_q |-> supply_monitor_active == ($past(deep_sleep_supply_watch_enable)
        && (!$past(regulator_enabled) || $past(deep_sleep_active))))
        else $error("supply monitor state wrong");
    a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    c_ctl_read: cover property (tk && !hwrite && ctl_a);
    c_request: cover property (rq);
    c_irq_rise: cover property ($rose(irq));
endmodule

bind rct_reset_cause rct_reset_cause_asserts rct_reset_cause_asserts_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wdt_timeout(wdt_timeout),
    .config_mismatch(config_mismatch), .reset_instruction(reset_instruction), .stack_full(stack_full),
    .stack_underflow(stack_underflow), .deep_sleep_reset(deep_sleep_reset), .deep_sleep_active(deep_sleep_active),
    .regulator_enabled(regulator_enabled), .deep_sleep_supply_watch_enable(deep_sleep_supply_watch_enable),
    .device_reset(device_reset), .interrupt_priority_enable(interrupt_priority_enable),
    .core_monitor_active(core_monitor_active), .supply_monitor_active(supply_monitor_active), .irq(irq));

// >>> bench/rct_reset_cause_tb_top.sv
// Self-checking bench for the reset cause tracker
`timescale 1ns/1ns
`include "rct_map.vh"
module rct_reset_cause_tb_top;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, pmm, reg_en, dsa;
    logic dsw = 1'b1;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, rdv, d;
    logic [10:0] rq;
    wire hreadyout, hresp, irq, cma, sma;
    wire [31:0] hrdata;
    int n_fail = 0;
    int num_checks = 0;
    int ctl, cause, stat, en;
    int unsigned seed = 7;
    int cx[9] = '{3, 4, 6, 7, 8, 9, 1, 5, 5};
    int fl[9] = '{8, 32, 16, 0, 0, 0, 0, 1, 1};
    always #20 hclk = ~hclk;
    rct_reset_cause rct_reset_cause_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .master_clear_pin_n(~rq[6]),
        .core_supply_low(rq[7]), .main_supply_low(rq[8]), .wdt_timeout(rq[0]), .config_mismatch(rq[1]),
        .reset_instruction(rq[2]), .stack_full(rq[3]), .stack_underflow(rq[4]), .deep_sleep_reset(rq[5]),
        .watchdog_clear_instruction(rq[10]), .sleep_instruction(rq[9]), .deep_sleep_active(dsa),
        .power_managed_mode(pmm), .regulator_enabled(reg_en), .deep_sleep_supply_watch_enable(dsw),
        .device_reset(), .interrupt_priority_enable(), .core_monitor_active(cma), .supply_monitor_active(sma),
        .irq(irq));
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait: a slave that never answers ends the run
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: bus answer timed out", $time);
            close_out();
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h00000, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task automatic check_all();
        rd(`RCT_CTRL_OFS, ctl);
        rd(`RCT_CAUSE_OFS, cause);
        rd(`RCT_STAT_OFS, stat);
        chk({31'h0, irq}, {31'h0, (stat & en) != 0});
        chk({30'h0, cma, sma}, {30'h0, reg_en & ~dsa, dsw & (~reg_en | dsa)});
    endtask
    // Pins pass a synchroniser, so they are held long enough to be seen
    task automatic ev(input int i, input int h);
        @(posedge hclk);
        rq[i] <= 1'b1;
        repeat (h) @(posedge hclk);
        rq[i] <= 1'b0;
        repeat (8) @(posedge hclk);
        if (i == 9) begin
            ctl = (ctl & ~4) | 8;
        end else if (i == 10) begin
            ctl = ctl | 12;
        end else begin
            ctl = ctl & ~(128 | fl[i]);
            cause = 1 << ((i == 6 && pmm) ? 2 : cx[i]);
            stat = stat | cause;
        end
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        ctl = 'h3C;
        cause = 1;
        stat = 1;
        en = 0;
    endtask
    initial begin
        {hresetn, hsel, hwrite, pmm, reg_en, dsa, htrans, haddr, hwdata, rq} = '0;
        do_reset();
        check_all();
        rd(`RCT_EN_OFS, 0);
        rd(12'hFE4, 0);
        rd(`RCT_CLR_OFS, 0);
        for (int j = 0; j < 4; j++) begin
            dsw <= xs() % 2;
            // Bit 0 always written as 1 so the regulator-off mask is really exercised
            d = xs() | 1;
            bus(1'b1, `RCT_CTRL_OFS, d);
            ctl = (ctl & 'h4C) | (d & 'hB2);
            rd(`RCT_CTRL_OFS, ctl);
            chk({31'h0, sma}, {31'h0, dsw});
        end
        dsw <= 1'b1;
        reg_en <= 1'b1;
        bus(1'b1, `RCT_EN_OFS, 'h3FF);
        en = 'h3FF;
        bus(1'b1, `RCT_CLR_OFS, 'h3FF);
        stat = 0;
        for (int i = 0; i < 9; i++) begin
            pmm <= xs() % 2;
            dsa <= (i == 8);
            bus(1'b1, `RCT_CTRL_OFS, 'hFF);
            // Time-out and power-down flags are read-only and keep their state
            ctl = 'hB3 | (ctl & 'h0C);
            ev(i, i > 5 ? 6 : 1);
            check_all();
        end
        dsa <= 1'b0;
        ev(0, 1);
        ev(9, 1);
        check_all();
        ev(10, 1);
        check_all();
        bus(1'b1, `RCT_CLR_OFS, 'h3FF);
        stat = 0;
        bus(1'b1, `RCT_EN_OFS, 'h008);
        en = 8;
        ev(0, 1);
        check_all();
        bus(1'b1, `RCT_EN_OFS, 0);
        en = 0;
        check_all();
        do_reset();
        check_all();
        close_out();
    end
endmodule

// >>> design/rct_map.vh
// Register map, field positions and reset values of the reset cause tracker
`ifndef RCT_MAP_VH
`define RCT_MAP_VH

`define RCT_ADDR_W 12
`define RCT_CTRL_OFS 12'hFD0
`define RCT_CAUSE_OFS 12'hFD4
`define RCT_STAT_OFS 12'hFD8
`define RCT_EN_OFS 12'hFDC
`define RCT_CLR_OFS 12'hFE0

`define RCT_BIT_BROWN 0
`define RCT_BIT_POR 1
`define RCT_BIT_PDOWN 2
`define RCT_BIT_WDTO 3
`define RCT_BIT_RSTI 4
`define RCT_BIT_CFGM 5
`define RCT_BIT_PRIO 7

`define RCT_CTRL_RST 8'h3C
`define RCT_CTRL_WMASK 8'hB3

`define RCT_NCAUSE 10
`define RCT_CAUSE_POR 0
`define RCT_CAUSE_MCP_RUN 1
`define RCT_CAUSE_MCP_PM 2
`define RCT_CAUSE_WDT 3
`define RCT_CAUSE_CFGM 4
`define RCT_CAUSE_BROWN 5
`define RCT_CAUSE_RSTI 6
`define RCT_CAUSE_STKFUL 7
`define RCT_CAUSE_STKUNF 8
`define RCT_CAUSE_DSLEEP 9
`define RCT_CAUSE_RST 10'h001
`define RCT_STAT_RST 10'h001
`define RCT_EN_RST 10'h000

`define RCT_NSYNC 3
`define RCT_SYNC_RST 3'h1

`endif

// >>> design/rct_reset_cause.v
// Reset cause tracker with AHB-Lite register access and cause interrupts
`timescale 1ns/1ns
`include "rct_map.vh"
module rct_reset_cause (
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hrdata,
    hresp,
    master_clear_pin_n,
    core_supply_low,
    main_supply_low,
    wdt_timeout,
    config_mismatch,
    reset_instruction,
    stack_full,
    stack_underflow,
    deep_sleep_reset,
    watchdog_clear_instruction,
    sleep_instruction,
    deep_sleep_active,
    power_managed_mode,
    regulator_enabled,
    deep_sleep_supply_watch_enable,
    device_reset,
    interrupt_priority_enable,
    core_monitor_active,
    supply_monitor_active,
    irq
);
    input wire hclk;
    input wire hresetn;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output wire hreadyout;
    output wire [31:0] hrdata;
    output wire hresp;
    input wire master_clear_pin_n;
    input wire core_supply_low;
    input wire main_supply_low;
    input wire wdt_timeout;
    input wire config_mismatch;
    input wire reset_instruction;
    input wire stack_full;
    input wire stack_underflow;
    input wire deep_sleep_reset;
    input wire watchdog_clear_instruction;
    input wire sleep_instruction;
    input wire deep_sleep_active;
    input wire power_managed_mode;
    input wire regulator_enabled;
    input wire deep_sleep_supply_watch_enable;
    output wire device_reset;
    output wire interrupt_priority_enable;
    output wire core_monitor_active;
    output wire supply_monitor_active;
    output wire irq;

    // Synchronised pin and comparator inputs
    wire [`RCT_NSYNC-1:0] async_raw;
    wire [`RCT_NSYNC-1:0] async_syn;
    localparam [`RCT_NSYNC-1:0] SYNC_RST = `RCT_SYNC_RST;
    wire mcp_n_s;
    wire core_low_s;
    wire main_low_s;

    // Event sources and edges
    wire [`RCT_NCAUSE-1:0] ev_lvl;
    reg [`RCT_NCAUSE-1:0] ev_prev_q;
    wire [`RCT_NCAUSE-1:0] ev_rise;
    wire any_event;
    wire core_trip;
    wire main_trip;
    wire brown_event;

    // Control register fields
    reg prio_en_q;
    reg cfgm_n_q;
    reg rsti_n_q;
    reg wdto_n_q;
    reg pdown_n_q;
    reg por_n_q;
    reg brown_n_q;
    wire [7:0] ctrl_rd;

    // Cause, status and enable registers
    reg [`RCT_NCAUSE-1:0] cause_q;
    reg [`RCT_NCAUSE-1:0] stat_q;
    reg [`RCT_NCAUSE-1:0] en_q;

    // Outputs held in flip-flops
    reg dev_reset_q;
    reg core_mon_q;
    reg main_mon_q;
    reg irq_q;

    // Bus state
    reg dp_wr_q;
    reg dp_rd_q;
    reg [`RCT_ADDR_W-1:0] dp_addr_q;
    reg hreadyout_q;
    reg [31:0] hrdata_q;
    reg [31:0] rd_mux;
    wire addr_take;
    wire wr_ctrl;
    wire wr_en;
    wire wr_clr;
    wire [`RCT_NCAUSE-1:0] clr_bits;

    assign async_raw = {main_supply_low, core_supply_low, master_clear_pin_n};

    genvar gi;
    generate
        for (gi = 0; gi < `RCT_NSYNC; gi = gi + 1) begin : g_sync
            rct_sync #(
                .RST_VAL(SYNC_RST[gi])
            ) u_sync (
                .hclk(hclk),
                .hresetn(hresetn),
                .async_in(async_raw[gi]),
                .sync_out(async_syn[gi])
            );
        end
    endgenerate

    assign mcp_n_s = async_syn[0];
    assign core_low_s = async_syn[1];
    assign main_low_s = async_syn[2];

    // Monitors only trip while they are allowed to run
    assign core_trip = core_mon_q & core_low_s;
    assign main_trip = main_mon_q & main_low_s;
    assign brown_event = core_trip | main_trip;

    // Power-on is delivered by hresetn itself, so its level input is never high here
    assign ev_lvl[`RCT_CAUSE_POR] = 1'b0;
    assign ev_lvl[`RCT_CAUSE_MCP_RUN] = ~mcp_n_s & ~power_managed_mode;
    assign ev_lvl[`RCT_CAUSE_MCP_PM] = ~mcp_n_s & power_managed_mode;
    assign ev_lvl[`RCT_CAUSE_WDT] = wdt_timeout;
    assign ev_lvl[`RCT_CAUSE_CFGM] = config_mismatch;
    assign ev_lvl[`RCT_CAUSE_BROWN] = brown_event;
    assign ev_lvl[`RCT_CAUSE_RSTI] = reset_instruction;
    assign ev_lvl[`RCT_CAUSE_STKFUL] = stack_full;
    assign ev_lvl[`RCT_CAUSE_STKUNF] = stack_underflow;
    assign ev_lvl[`RCT_CAUSE_DSLEEP] = deep_sleep_reset;

    assign ev_rise = ev_lvl & ~ev_prev_q;
    assign any_event = |ev_lvl;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_prev_q <= {`RCT_NCAUSE{1'b0}};
            dev_reset_q <= 1'b0;
            core_mon_q <= 1'b0;
            main_mon_q <= 1'b0;
        end else begin
            ev_prev_q <= ev_lvl;
            dev_reset_q <= any_event;
            core_mon_q <= regulator_enabled & ~deep_sleep_active;
            if (regulator_enabled) begin
                main_mon_q <= deep_sleep_supply_watch_enable & deep_sleep_active;
            end else begin
                main_mon_q <= deep_sleep_supply_watch_enable;
            end
        end
    end

    // Last cause holds the newest reset; simultaneous causes all show
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_q <= `RCT_CAUSE_RST;
        end else if (|ev_rise) begin
            cause_q <= ev_rise;
        end
    end

    // AHB-Lite slave: writes take no wait state, reads take one
    assign addr_take = hsel & htrans[1] & hready;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_rd_q <= 1'b0;
            dp_addr_q <= {`RCT_ADDR_W{1'b0}};
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end else begin
            if (addr_take) begin
                dp_wr_q <= hwrite;
                dp_rd_q <= ~hwrite;
                dp_addr_q <= haddr[`RCT_ADDR_W-1:0];
                hreadyout_q <= hwrite;
            end else if (hready) begin
                dp_wr_q <= 1'b0;
                dp_rd_q <= 1'b0;
            end
            // Read data is sampled in the stall cycle so a preceding write is seen
            if (dp_rd_q && !hreadyout_q) begin
                hrdata_q <= rd_mux;
                hreadyout_q <= 1'b1;
            end
        end
    end

    assign wr_ctrl = dp_wr_q & (dp_addr_q == `RCT_CTRL_OFS);
    assign wr_en = dp_wr_q & (dp_addr_q == `RCT_EN_OFS);
    assign wr_clr = dp_wr_q & (dp_addr_q == `RCT_CLR_OFS);
    assign clr_bits = wr_clr ? hwdata[`RCT_NCAUSE-1:0] : {`RCT_NCAUSE{1'b0}};

    // Bit 6 is a constant zero; bit 0 is masked when the regulator is off
    assign ctrl_rd = {prio_en_q, 1'b0, cfgm_n_q, rsti_n_q, wdto_n_q, pdown_n_q, por_n_q,
                      brown_n_q & regulator_enabled};

    always @* begin
        rd_mux = 32'h00000000;
        case (dp_addr_q)
            `RCT_CTRL_OFS: begin
                rd_mux[7:0] = ctrl_rd;
            end
            `RCT_CAUSE_OFS: begin
                rd_mux[`RCT_NCAUSE-1:0] = cause_q;
            end
            `RCT_STAT_OFS: begin
                rd_mux[`RCT_NCAUSE-1:0] = stat_q;
            end
            `RCT_EN_OFS: begin
                rd_mux[`RCT_NCAUSE-1:0] = en_q;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // Control flags: hresetn is the power-on reset and gives the power-up values.
    // A hardware event beats a software write in the same cycle.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prio_en_q <= 1'b0;
            cfgm_n_q <= 1'b1;
            rsti_n_q <= 1'b1;
            wdto_n_q <= 1'b1;
            pdown_n_q <= 1'b1;
            por_n_q <= 1'b0;
            brown_n_q <= 1'b0;
        end else begin
            // Priority enable drops on any reset so the core restarts single level
            if (any_event) begin
                prio_en_q <= 1'b0;
            end else if (wr_ctrl) begin
                prio_en_q <= hwdata[`RCT_BIT_PRIO];
            end

            if (ev_lvl[`RCT_CAUSE_CFGM]) begin
                cfgm_n_q <= 1'b0;
            end else if (wr_ctrl) begin
                cfgm_n_q <= hwdata[`RCT_BIT_CFGM];
            end

            if (ev_lvl[`RCT_CAUSE_RSTI]) begin
                rsti_n_q <= 1'b0;
            end else if (wr_ctrl) begin
                rsti_n_q <= hwdata[`RCT_BIT_RSTI];
            end

            // Read-only: time-out wins over a clear or sleep in the same cycle
            if (ev_lvl[`RCT_CAUSE_WDT]) begin
                wdto_n_q <= 1'b0;
            end else if (watchdog_clear_instruction || sleep_instruction) begin
                wdto_n_q <= 1'b1;
            end

            if (sleep_instruction) begin
                pdown_n_q <= 1'b0;
            end else if (watchdog_clear_instruction) begin
                pdown_n_q <= 1'b1;
            end

            // Only software sets this one; no other reset touches it
            if (wr_ctrl) begin
                por_n_q <= hwdata[`RCT_BIT_POR];
            end

            // Held low without a regulator so a write cannot leave a stale 1
            if (!regulator_enabled) begin
                brown_n_q <= 1'b0;
            end else if (brown_event) begin
                brown_n_q <= 1'b0;
            end else if (wr_ctrl) begin
                brown_n_q <= hwdata[`RCT_BIT_BROWN];
            end
        end
    end

    // Sticky cause status; a new event wins over a clear in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= `RCT_STAT_RST;
            en_q <= `RCT_EN_RST;
            irq_q <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~clr_bits) | ev_rise;
            if (wr_en) begin
                en_q <= hwdata[`RCT_NCAUSE-1:0];
            end
            irq_q <= |(stat_q & en_q);
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    assign device_reset = dev_reset_q;
    assign interrupt_priority_enable = prio_en_q;
    assign core_monitor_active = core_mon_q;
    assign supply_monitor_active = main_mon_q;
    assign irq = irq_q;

    // Unused address and size bits: hsize is not checked, so an access of any size to a register offset is decoded
    wire unused_ok;
    assign unused_ok = &{1'b0, haddr[31:`RCT_ADDR_W], hsize, htrans[0], hwdata[31:8]};
endmodule

// >>> design/rct_sync.v
// Three-stage input synchroniser that accepts a change once two stages agree
`timescale 1ns/1ns
module rct_sync #(
    parameter RST_VAL = 1'b0
) (
    hclk,
    hresetn,
    async_in,
    sync_out
);
    input wire hclk;
    input wire hresetn;
    input wire async_in;
    output wire sync_out;

    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg out_q;

    // Stage one feeds stage two only, to keep metastability away from logic
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end

    assign sync_out = out_q;
endmodule
